//--- logic/brmc_consts.svh
`ifndef BRMC_CONSTS_SVH
`define BRMC_CONSTS_SVH
// Register addresses on the register-bank port
`define BRMC_ADDR_MEM_CTRL 8'h37
`define BRMC_ADDR_RAIL_A_CTRL 8'h38
`define BRMC_ADDR_RAIL_B_CTRL 8'h39
// Current readback registers
`define BRMC_ADDR_MEM_CURR 8'h3d
`define BRMC_ADDR_RAIL_A_CURR 8'h3e
`define BRMC_ADDR_RAIL_B_CURR 8'h3f
// Reset values
`define BRMC_RST_MEM_CTRL 8'h04
`define BRMC_RST_RAIL_A_CTRL 8'h07
`define BRMC_RST_RAIL_B_CTRL 8'h07
// Field positions
`define BRMC_STATE_LSB 0
`define BRMC_STATE_MSB 2
`define BRMC_EXIT_LSB 3
`define BRMC_EXIT_MSB 5
`define BRMC_VSEL_LSB 6
`define BRMC_VSEL_MSB 7
// Rail indices
`define BRMC_RAIL_MEM 0
`define BRMC_RAIL_A 1
`define BRMC_RAIL_B 2
`endif

//--- logic/brmc_pkg.sv
package brmc_pkg;
  // Rail operating state codes; codes 0 to 3 are reserved
  typedef enum logic [2:0] {
    BRMC_OFF = 3'h4,
    BRMC_PFM = 3'h5,
    BRMC_APS = 3'h6,
    BRMC_PWM = 3'h7
  } brmc_mode_e;
  // Output level select of rail b
  typedef enum logic [1:0] {
    BRMC_V1P5 = 2'h0,
    BRMC_V1P6 = 2'h1
  } brmc_vsel_e;
  typedef logic [7:0] brmc_byte_t;
endpackage

//--- logic/brmc_rail_if.sv
`timescale 1ns/100ps
interface brmc_rail_if;
  logic [2:0] state;
  logic discharge;
  logic fault;
  modport ctrl (output state, input discharge, input fault);
  modport rail (input state, output discharge, output fault);
endinterface

//--- logic/brmc_rail.sv
`timescale 1ns/100ps
module brmc_rail
  import brmc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ocp_i,
  brmc_rail_if.rail rif
);
  logic ocp_s1_q;
  logic ocp_s2_q;
  logic [2:0] prev_q;
  logic [2:0] prev_d;
  logic dis_q;
  logic dis_d;

  ////////////////////////////////////////////////////////////////////////////
  // Over-current comes from the analog side, so it is synchronised
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ocp_s1_q <= 1'b0;
      ocp_s2_q <= 1'b0;
    end
    else
    begin
      ocp_s1_q <= ocp_i;
      ocp_s2_q <= ocp_s1_q;
    end
  end

  assign rif.fault = ocp_s2_q; // R6

  ////////////////////////////////////////////////////////////////////////////
  // Discharge on every move into off; held while the rail stays off
  always_comb
  begin
    prev_d = rif.state;
    dis_d = dis_q;
    if (rif.state == BRMC_OFF && prev_q != BRMC_OFF)
    begin
      dis_d = 1'b1; // R7
    end
    else if (rif.state != BRMC_OFF)
    begin
      dis_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Start from off so a rail that powers up off sees no shutdown edge
      prev_q <= BRMC_OFF;
      dis_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      dis_q <= dis_d;
    end
  end

  assign rif.discharge = dis_q;
endmodule

//--- logic/brmc_top.sv
// Summary of operation
// [R1] State bits 2:0 pick off (4), PFM (5), pulse skipping (6) or PWM (7); 0 to 3 are reserved.
// [R2] A standby exit copies exit bits 5:3 into the state field when they hold 4 to 7.
// [R3] The host programs each exit field after power up before relying on standby exit.
// [R4] Memory rail control sits at 0x37, read/write, reset 0x04.
// [R5] Rail a control sits at 0x38, read/write, reset 0x07.
// [R6] Over-current raises the rail fault, and any rail fault raises the regulator fault.
// [R7] Each move of a rail into off starts its discharge through the low-side switch.
// [R8] Each rail's digitised output current is held in a host-readable register.
// [R9] When the positioning rail is at 1.3 V, rail b is forced to its 1.6 V level.
// [R10] Rail b control sits at 0x39, read/write, reset 0x07, same state and exit layout.
// [R11] Rail b bits 7:6 select 1.5 V (0) or 1.6 V (1); 2 and 3 are reserved.
// [R12] A reserved state code leaves the active state alone; bits 7:6 of the others read zero.
// [R13] The regulator fault follows the OR of the rail faults, clearing when all clear.

`timescale 1ns/100ps
`include "brmc_consts.svh"
module brmc_top
  import brmc_pkg::*;
#(
  parameter int RAILS = 3,
  parameter int ADC_W = 8
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  output logic [7:0] reg_rdata_o,
  input wire logic standby_exit_pin_i,
  input wire logic positioning_1v3_i,
  input wire logic [2:0] ocp_i,
  input wire logic [2:0] adc_valid_i,
  input wire logic [ADC_W-1:0] adc_data_i,
  output logic [2:0] rail_state_o,
  output logic [2:0] rail_a_state_o,
  output logic [2:0] rail_b_state_o,
  output logic [2:0] discharge_o,
  output logic [2:0] rail_fault_o,
  output logic rail_b_voltage_select_o,
  output logic regulator_fault_interrupt_o
);
  // Refuse sizes that the fixed decode and the byte-wide read mux cannot serve
  if (RAILS != 3 || ADC_W < 1 || ADC_W > 8)
  begin : g_bad_size
    $error("brmc_top: RAILS must be 3 and ADC_W 1..8");
  end

  // Register images, captured currents and the pin synchroniser stages
  brmc_byte_t ctrl_q [RAILS];
  brmc_byte_t ctrl_d [RAILS];
  logic [ADC_W-1:0] curr_q [RAILS];
  logic [ADC_W-1:0] curr_d [RAILS];
  logic exit_s1_q;
  logic exit_s2_q;
  logic exit_s3_q;
  logic pos_s1_q;
  logic pos_s2_q;
  logic exit_s1_d;
  logic exit_s2_d;
  logic exit_s3_d;
  logic pos_s1_d;
  logic pos_s2_d;
  logic exit_rise;
  logic vsel_field_hi;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pins from outside pass two flops; a third flop finds the exit edge
  always_comb
  begin
    exit_s1_d = standby_exit_pin_i;
    exit_s2_d = exit_s1_q;
    exit_s3_d = exit_s2_q;
    pos_s1_d = positioning_1v3_i;
    pos_s2_d = pos_s1_q;
  end

  // Stage registers only; nothing but the next stage reads a first flop
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      exit_s1_q <= 1'b0;
      exit_s2_q <= 1'b0;
      exit_s3_q <= 1'b0;
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
    end
    else
    begin
      exit_s1_q <= exit_s1_d;
      exit_s2_q <= exit_s2_d;
      exit_s3_q <= exit_s3_d;
      pos_s1_q <= pos_s1_d;
      pos_s2_q <= pos_s2_d;
    end
  end

  // Edge, not level, so a held pin does not undo later host writes
  assign exit_rise = exit_s2_q & ~exit_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-rail control register and current capture
  for (genvar r = 0; r < RAILS; r++)
  begin : g_rail
    // Address and power-up image of this rail's control register
    localparam logic [7:0] ADDR_C = (r == 0) ? `BRMC_ADDR_MEM_CTRL :
      (r == 1) ? `BRMC_ADDR_RAIL_A_CTRL : `BRMC_ADDR_RAIL_B_CTRL;
    localparam logic [7:0] RST_C = (r == 0) ? `BRMC_RST_MEM_CTRL :
      (r == 1) ? `BRMC_RST_RAIL_A_CTRL : `BRMC_RST_RAIL_B_CTRL;
    // Carrier between this control slice and the rail's own logic
    brmc_rail_if rif ();
    // Incoming state code and the stored exit code
    logic [2:0] ws;
    logic [2:0] ex;

    // Host write wins over a simultaneous standby exit: it is the newer intent
    always_comb
    begin
      ws = reg_wdata_i[`BRMC_STATE_MSB:`BRMC_STATE_LSB];
      ex = ctrl_q[r][`BRMC_EXIT_MSB:`BRMC_EXIT_LSB];
      ctrl_d[r] = ctrl_q[r];
      curr_d[r] = curr_q[r];
      if (reg_write_i && reg_addr_i == ADDR_C) // R4 R5 R10
      begin
        // A reserved state code still updates the exit field
        ctrl_d[r][`BRMC_EXIT_MSB:`BRMC_EXIT_LSB] = reg_wdata_i[`BRMC_EXIT_MSB:`BRMC_EXIT_LSB];
        if (ws[2]) // R1 R12
        begin
          ctrl_d[r][`BRMC_STATE_MSB:`BRMC_STATE_LSB] = ws;
        end
        if (r == `BRMC_RAIL_B) // R11
        begin
          ctrl_d[r][`BRMC_VSEL_MSB:`BRMC_VSEL_LSB] = reg_wdata_i[`BRMC_VSEL_MSB:`BRMC_VSEL_LSB];
        end
      end
      else if (exit_rise && ex[2]) // R2
      begin
        ctrl_d[r][`BRMC_STATE_MSB:`BRMC_STATE_LSB] = ex;
      end
      // A valid strobe overwrites the held sample; no averaging
      if (adc_valid_i[r]) // R8
      begin
        curr_d[r] = adc_data_i;
      end
    end

    // Control and current images; reset loads each rail's power-up image
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        ctrl_q[r] <= RST_C;
        curr_q[r] <= '0;
      end
      else
      begin
        ctrl_q[r] <= ctrl_d[r];
        curr_q[r] <= curr_d[r];
      end
    end

    // The rail slice sees only the active state field
    assign rif.state = ctrl_q[r][`BRMC_STATE_MSB:`BRMC_STATE_LSB];

    // Fault synchroniser and discharge logic of one rail
    brmc_rail u_rail (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .ocp_i(ocp_i[r]),
      .rif(rif.rail)
    );

    assign discharge_o[r] = rif.discharge; // R7
    assign rail_fault_o[r] = rif.fault;
  end

  // Active state of each rail, straight from the control images
  assign rail_state_o = ctrl_q[`BRMC_RAIL_MEM][`BRMC_STATE_MSB:`BRMC_STATE_LSB];
  assign rail_a_state_o = ctrl_q[`BRMC_RAIL_A][`BRMC_STATE_MSB:`BRMC_STATE_LSB];
  assign rail_b_state_o = ctrl_q[`BRMC_RAIL_B][`BRMC_STATE_MSB:`BRMC_STATE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Fault summary is a plain level; no latching, so it drops with the faults
  assign regulator_fault_interrupt_o = |rail_fault_o; // R6 R13

  // Only code 1 asks for the high level; reserved codes 2 and 3 stay at 1.5 V
  assign vsel_field_hi =
    (ctrl_q[`BRMC_RAIL_B][`BRMC_VSEL_MSB:`BRMC_VSEL_LSB] == BRMC_V1P6); // R11
  // Forced high level overrides the register field without changing it
  assign rail_b_voltage_select_o = pos_s2_q | vsel_field_hi; // R9 R11

  ////////////////////////////////////////////////////////////////////////////
  // Registered read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      `BRMC_ADDR_MEM_CTRL: rdata_d = {2'h0, ctrl_q[`BRMC_RAIL_MEM][5:0]}; // R12
      `BRMC_ADDR_RAIL_A_CTRL: rdata_d = {2'h0, ctrl_q[`BRMC_RAIL_A][5:0]}; // R12
      `BRMC_ADDR_RAIL_B_CTRL: rdata_d = ctrl_q[`BRMC_RAIL_B];
      `BRMC_ADDR_MEM_CURR: rdata_d = 8'(curr_q[`BRMC_RAIL_MEM]); // R8
      `BRMC_ADDR_RAIL_A_CURR: rdata_d = 8'(curr_q[`BRMC_RAIL_A]);
      `BRMC_ADDR_RAIL_B_CURR: rdata_d = 8'(curr_q[`BRMC_RAIL_B]);
      default: rdata_d = 8'h00;
    endcase
  end

  // One stage: read data answers the address seen at the last edge
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
endmodule

//--- bench/brmc_checker.sv
`timescale 1ns/100ps
module brmc_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic positioning_1v3_i,
  input wire logic [2:0] ocp_i,
  input wire logic [2:0] rail_state_o,
  input wire logic [2:0] rail_a_state_o,
  input wire logic [2:0] discharge_o,
  input wire logic [2:0] rail_fault_o,
  input wire logic rail_b_voltage_select_o,
  input wire logic regulator_fault_interrupt_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////
  // Faults trail over-current by the two sync flops
  fault_lag_a: assert property ($past(resetn_i, 2) |-> rail_fault_o == $past(ocp_i, 2))
    else $error("rail fault lag wrong");
  irq_or_a: assert property (regulator_fault_interrupt_o == |rail_fault_o)
    else $error("fault interrupt not the OR of rail faults");
  disch_on_a: assert property ($rose(rail_state_o == 3'h4) |=> discharge_o[0])
    else $error("no discharge on shutdown");
  disch_off_a: assert property ($fell(rail_a_state_o == 3'h4) |=> !discharge_o[1])
    else $error("discharge kept after leaving off");
  state_wr_a: assert property (reg_write_i && reg_addr_i == 8'h37 && reg_wdata_i[2]
    |=> rail_state_o == $past(reg_wdata_i[2:0]))
    else $error("state write not applied");
  resv_state_a: assert property (reg_write_i && reg_addr_i == 8'h38 && !reg_wdata_i[2]
    |=> $stable(rail_a_state_o))
    else $error("reserved state code applied");
  resv_bits_a: assert property ((reg_addr_i == 8'h37 || reg_addr_i == 8'h38)
    |=> reg_rdata_o[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  vsel_force_a: assert property ($past(positioning_1v3_i, 2) |-> rail_b_voltage_select_o)
    else $error("rail b not raised");
  vsel_field_a: assert property (reg_write_i && reg_addr_i == 8'h39 && reg_wdata_i[7:6] == 2'h1
    |=> rail_b_voltage_select_o)
    else $error("level select field ignored");
  cover property ($rose(regulator_fault_interrupt_o));
  cover property ($rose(discharge_o[0]));
  cover property ($rose(rail_b_voltage_select_o));
endmodule
bind brmc_top brmc_checker brmc_checker_inst (.clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_rdata_o, .positioning_1v3_i, .ocp_i, .rail_state_o, .rail_a_state_o,
  .discharge_o, .rail_fault_o, .rail_b_voltage_select_o, .regulator_fault_interrupt_o);

//--- bench/brmc_host.sv
`timescale 1ns/100ps
module brmc_host (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic write_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    write_o = 1'b0;
  end
  // One-cycle strobe per byte; the exit fields are programmed through here
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= v;
    write_o <= 1'b1;
    @(posedge clock_i);
    write_o <= 1'b0;
    wdata_o <= ~v; // Stale data must not look valid
  endtask
  // Read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_o <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    v = rdata_i;
  endtask
endmodule

//--- bench/buck_rail_mode_control_test.sv
`timescale 1ns/100ps
module buck_rail_mode_control_test;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pin = 1'b0;
  logic pos = 1'b0;
  logic [2:0] ocp = 3'h0;
  logic [2:0] av = 3'h0;
  logic [7:0] ad = 8'h00;
  logic [7:0] addr, wdata, rdata, d;
  logic write, vsel, irq;
  logic [8:0] st;
  logic [2:0] dis, flt;
  int fail_count = 0;
  int num_checks = 0;
  always #12.5 clock_i = ~clock_i;
  brmc_host brmc_host_inst (.clock_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .write_o(write));
  brmc_top brmc_top_inst (.clock_i, .resetn_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(write), .reg_rdata_o(rdata), .standby_exit_pin_i(pin), .positioning_1v3_i(pos),
    .ocp_i(ocp), .adc_valid_i(av), .adc_data_i(ad), .rail_state_o(st[2:0]),
    .rail_a_state_o(st[5:3]), .rail_b_state_o(st[8:6]), .discharge_o(dis), .rail_fault_o(flt),
    .rail_b_voltage_select_o(vsel), .regulator_fault_interrupt_o(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    brmc_host_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run is about 110 cycles; this limit is far beyond it
  initial
  begin
    #60000;
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rc(8'h37, 8'h04);
    rc(8'h38, 8'h07);
    rc(8'h39, 8'h07);
    rc(8'h3d, 8'h00);
    rc(8'h3a, 8'h00);
    chk(8'(dis), 8'h00);
    // Walk down to off so every rail sees a real shutdown
    for (int r = 0; r < 3; r++)
      for (int c = 7; c > 3; c--)
      begin
        brmc_host_inst.wr(8'h37 + 8'(r), 8'(c));
        tick(1);
        chk(8'(st[3*r+:3]), 8'(c));
        chk(8'(dis[r]), 8'(c == 4));
      end
    brmc_host_inst.wr(8'h37, 8'h02);
    tick(1);
    chk(8'(st[2:0]), 8'h04);
    brmc_host_inst.wr(8'h38, 8'hff);
    rc(8'h38, 8'h3f);
    brmc_host_inst.wr(8'h38, 8'h01);
    rc(8'h38, 8'h07);
    brmc_host_inst.wr(8'h39, 8'hc4);
    rc(8'h39, 8'hc4);
    chk(8'(vsel), 8'h00);
    brmc_host_inst.wr(8'h39, 8'h47);
    tick(0);
    chk(8'(vsel), 8'h01);
    $display("end registers");
    brmc_host_inst.wr(8'h37, 8'h2c);
    brmc_host_inst.wr(8'h38, 8'h17);
    brmc_host_inst.wr(8'h39, 8'h34);
    @(posedge clock_i);
    pin <= 1'b1;
    tick(4);
    chk(8'(st[2:0]), 8'h05);
    chk(8'(st[8:3]), 8'h37);
    @(posedge clock_i);
    pin <= 1'b0;
    $display("end standby exit");
    for (int r = 0; r < 3; r++)
    begin
      @(posedge clock_i);
      ocp <= 3'(1 << r);
      tick(3);
      chk(8'({irq, flt}), 8'(8 | (1 << r)));
      @(posedge clock_i);
      ocp <= 3'h0;
      tick(3);
      chk(8'({irq, flt}), 8'h00);
    end
    @(posedge clock_i);
    pos <= 1'b1;
    tick(3);
    chk(8'(vsel), 8'h01);
    @(posedge clock_i);
    pos <= 1'b0;
    av <= 3'h2;
    ad <= 8'h5a;
    @(posedge clock_i);
    av <= 3'h0;
    rc(8'h3e, 8'h5a);
    chk(8'(vsel), 8'h00);
    $display("end faults and sensing");
    final_report();
  end
endmodule
